// [hw/lmc_consts.vh]
// Constants for the resonant actuator loop mode control
`ifndef LMC_CONSTS_VH
`define LMC_CONSTS_VH
`define LMC_ADDR_W          8
`define LMC_ADDR_TYPE       8'h1A
`define LMC_ADDR_AUTO_OL    8'h1F
`define LMC_ADDR_OL_PERIOD  8'h20
`define LMC_ADDR_PERIOD     8'h22
`define LMC_ADDR_DRIVE      8'h30
`define LMC_ADDR_STATUS     8'h31
`define LMC_BIT_TYPE        7
`define LMC_BIT_BOOST       7
`define LMC_BIT_AUTO_OL     5
`define LMC_AUTO_CNT_HI     3
`define LMC_AUTO_CNT_LO     2
`define LMC_RST_TYPE        8'h00
`define LMC_RST_AUTO_OL     8'h00
`define LMC_RST_OL_PERIOD   8'h33
`define LMC_RST_DRIVE       8'h13
`define LMC_RST_ZC          2'h1
`define LMC_UNIT_NS         98490
`define LMC_CLK_NS          25
`define LMC_UNIT_CYC        ((`LMC_UNIT_NS) / (`LMC_CLK_NS))
`define LMC_DRV_UNIT_CYC    16'h0FA0
`define LMC_ZC_UNIT_CYC     16'h0FA0
`define LMC_PER_MAX         16'hFFFF
`define LMC_BOOST_CYC       8'h40
// Nearest whole clock to half of one 98.49 us period unit
`define LMC_OL_HALF_CYC     16'h07B2
`define LMC_DRV_HI          4
`define LMC_DRV_LO          0
`define LMC_ZC_HI           6
`define LMC_ZC_LO           5
`endif

// [hw/lmc_loop_ctrl.v]
// Loop mode control: resonance tracking, open-loop fallback, overdrive and brake
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "lmc_consts.vh"
module lmc_loop_ctrl
(
   input  wire        clk_i,
   input  wire        resetn_i,
   input  wire [7:0]  addr_i,
   input  wire [7:0]  wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [7:0]  rdata_o,
   input  wire        wave_active_i,
   input  wire        zc_i,
   input  wire        bemf_valid_i,
   output reg         drive_phase_o,
   output reg         drive_en_o,
   output reg         overdrive_o,
   output reg         brake_o,
   output reg         gain_boost_o,
   output reg         lra_mode_o,
   output reg         open_loop_o,
   output reg         synced_o
);
   localparam ST_IDLE  = 4'b0001;
   localparam ST_CLOSE = 4'b0010;
   localparam ST_OPEN  = 4'b0100;
   localparam ST_BRAKE = 4'b1000;

   reg [7:0]  reg_type;
   reg [7:0]  reg_auto;
   reg [7:0]  reg_olp;
   reg [7:0]  reg_drive;
   reg [3:0]  state;
   reg        latched_ol;
   reg [1:0]  unsync_cnt;
   reg [23:0] ph_cnt;
   reg [23:0] ph_limit;
   reg [7:0]  boost_cnt;
   reg        wave_q;
   reg        next_phase_tick;
   reg        next_cycle_tick;
   reg [23:0] drv_units;
   reg [23:0] zc_units;
   reg [23:0] fall_half;
   wire       locked;
   wire [15:0] half_period;
   wire       is_lra;
   wire       start;

   // Clock cycles in n timing units
   function [23:0] mul_units;
      input [7:0]  n;
      input [15:0] unit;
      begin
         mul_units = n * unit;
      end
   endfunction

   // Tracker runs on every waveform, fed straight from back-EMF
   lmc_tracker u_trk
   (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .run_i         (wave_active_i),
      .zc_i          (zc_i),
      .bemf_valid_i  (bemf_valid_i),
      .locked_o      (locked),
      .half_period_o (half_period)
   );

   assign is_lra = reg_type[`LMC_BIT_TYPE];
   assign start  = wave_active_i & ~wave_q;

   // Register port
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         reg_type  <= `LMC_RST_TYPE;
         reg_auto  <= `LMC_RST_AUTO_OL;
         reg_olp   <= `LMC_RST_OL_PERIOD;
         reg_drive <= `LMC_RST_DRIVE;
         rdata_o   <= 8'h00;
      end
      else
      begin
         if (wr_i)
         begin
            if (addr_i == `LMC_ADDR_TYPE)
               reg_type <= wdata_i;
            else if (addr_i == `LMC_ADDR_AUTO_OL)
               reg_auto <= wdata_i;
            else if (addr_i == `LMC_ADDR_OL_PERIOD)
               reg_olp <= {1'b0, wdata_i[6:0]};
            else if (addr_i == `LMC_ADDR_DRIVE)
               reg_drive <= wdata_i;
         end
         if (rd_i)
         begin
            if (addr_i == `LMC_ADDR_TYPE)
               rdata_o <= reg_type;
            else if (addr_i == `LMC_ADDR_AUTO_OL)
               rdata_o <= reg_auto;
            else if (addr_i == `LMC_ADDR_OL_PERIOD)
               rdata_o <= reg_olp;
            else if (addr_i == `LMC_ADDR_PERIOD)
               rdata_o <= half_period[15:8];
            else if (addr_i == `LMC_ADDR_DRIVE)
               rdata_o <= reg_drive;
            else if (addr_i == `LMC_ADDR_STATUS)
               rdata_o <= {4'h0, latched_ol, synced_o, unsync_cnt};
            else
               rdata_o <= 8'h00;
         end
         else
            rdata_o <= 8'h00;
      end
   end

   // Open-loop half period select
   always @*
   begin
      drv_units = mul_units({3'h0, reg_drive[`LMC_DRV_HI:`LMC_DRV_LO]}, `LMC_DRV_UNIT_CYC);
      zc_units  = mul_units({6'h00, reg_drive[`LMC_ZC_HI:`LMC_ZC_LO]}, `LMC_ZC_UNIT_CYC);
      // A zero-cross window as long as the drive time would wrap the count
      if (drv_units > zc_units)
         fall_half = drv_units - zc_units;
      else
         fall_half = {8'h00, `LMC_DRV_UNIT_CYC};
      if (latched_ol)
         ph_limit = mul_units(reg_olp, `LMC_OL_HALF_CYC);
      else
         ph_limit = fall_half;
      next_phase_tick = (ph_cnt + 24'h000001 >= ph_limit);
      // Miss timing uses a whole default cycle, two half periods
      next_cycle_tick = (ph_cnt + 24'h000001 >= {ph_limit[22:0], 1'b0});
   end

   // Mode state machine
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state        <= ST_IDLE;
         wave_q       <= 1'b0;
         latched_ol   <= 1'b0;
         unsync_cnt   <= 2'h0;
         ph_cnt       <= 24'h000000;
         boost_cnt    <= 8'h00;
         drive_phase_o <= 1'b0;
         drive_en_o   <= 1'b0;
         overdrive_o  <= 1'b0;
         brake_o      <= 1'b0;
         gain_boost_o <= 1'b0;
         lra_mode_o   <= 1'b0;
         open_loop_o  <= 1'b0;
         synced_o     <= 1'b0;
      end
      else
      begin
         wave_q     <= wave_active_i;
         lra_mode_o <= is_lra;
         if (start)
         begin
            unsync_cnt <= 2'h0;
            latched_ol <= 1'b0;
            boost_cnt  <= `LMC_BOOST_CYC;
         end
         else if (boost_cnt != 8'h00)
            boost_cnt <= boost_cnt - 8'h01;
         case (state)
            ST_IDLE:
            begin
               // Idle holds every drive output off except drive_phase_o, which keeps its last level
               drive_en_o   <= 1'b0;
               brake_o      <= 1'b0;
               overdrive_o  <= 1'b0;
               gain_boost_o <= 1'b0;
               synced_o     <= 1'b0;
               ph_cnt       <= 24'h000000;
               if (wave_active_i)
                  state <= ST_CLOSE;
            end
            ST_CLOSE:
            begin
               drive_en_o   <= 1'b1;
               overdrive_o  <= 1'b1;
               gain_boost_o <= reg_auto[`LMC_BIT_BOOST] && (boost_cnt != 8'h00);
               synced_o     <= is_lra & locked;
               if (!wave_active_i)
               begin
                  // Overdrive drops with the waveform so braking starts clean
                  overdrive_o <= 1'b0;
                  state       <= ST_BRAKE;
               end
               else if (is_lra && locked)
               begin
                  unsync_cnt <= 2'h0;
                  ph_cnt     <= 24'h000000;
               end
               else if (is_lra && reg_auto[`LMC_BIT_AUTO_OL])
               begin
                  // Unlocked time is counted in default drive cycles
                  if (next_cycle_tick)
                  begin
                     ph_cnt <= 24'h000000;
                     if (unsync_cnt == reg_auto[`LMC_AUTO_CNT_HI:`LMC_AUTO_CNT_LO])
                     begin
                        // One-way: no path back until the next waveform
                        latched_ol <= 1'b1;
                        state      <= ST_OPEN;
                     end
                     else
                        unsync_cnt <= unsync_cnt + 2'h1;
                  end
                  else
                     ph_cnt <= ph_cnt + 24'h000001;
               end
               else if (is_lra && !bemf_valid_i)
               begin
                  ph_cnt <= 24'h000000;
                  state  <= ST_OPEN;
               end
            end
            ST_OPEN:
            begin
               drive_en_o   <= 1'b1;
               open_loop_o  <= 1'b1;
               synced_o     <= 1'b0;
               gain_boost_o <= 1'b0;
               overdrive_o  <= ~latched_ol;
               if (next_phase_tick)
               begin
                  ph_cnt        <= 24'h000000;
                  drive_phase_o <= ~drive_phase_o;
               end
               else
                  ph_cnt <= ph_cnt + 24'h000001;
               if (!wave_active_i)
               begin
                  open_loop_o <= 1'b0;
                  overdrive_o <= 1'b0;
                  // No brake after auto open loop
                  if (latched_ol)
                     state <= ST_IDLE;
                  else
                     state <= ST_BRAKE;
               end
               else if (!latched_ol && bemf_valid_i)
               begin
                  open_loop_o <= 1'b0;
                  ph_cnt      <= 24'h000000;
                  state       <= ST_CLOSE;
               end
            end
            ST_BRAKE:
            begin
               overdrive_o  <= 1'b0;
               gain_boost_o <= 1'b0;
               synced_o     <= 1'b0;
               brake_o      <= 1'b1;
               drive_en_o   <= 1'b1;
               // Brake ends when back-EMF dies out
               if (wave_active_i)
               begin
                  brake_o <= 1'b0;
                  ph_cnt  <= 24'h000000;
                  state   <= ST_CLOSE;
               end
               else if (!bemf_valid_i)
               begin
                  brake_o    <= 1'b0;
                  drive_en_o <= 1'b0;
                  state      <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
         // Closed loop flips polarity at each crossing it trusts
         if (state == ST_CLOSE && zc_i && !(is_lra && !bemf_valid_i))
         begin
            drive_phase_o <= ~drive_phase_o;
         end
      end
   end
endmodule // lmc_loop_ctrl

// [hw/lmc_tracker.v]
// Back-EMF zero-cross resonance tracker, needs no calibration
`include "lmc_consts.vh"
module lmc_tracker
(
   input  wire        clk_i,
   input  wire        resetn_i,
   input  wire        run_i,
   input  wire        zc_i,
   input  wire        bemf_valid_i,
   output reg         locked_o,
   output reg  [15:0] half_period_o
);
   reg [15:0] cnt;
   reg        seen;

   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt           <= 16'h0000;
         seen          <= 1'b0;
         locked_o      <= 1'b0;
         half_period_o <= 16'h0000;
      end
      else if (!run_i || !bemf_valid_i)
      begin
         cnt      <= 16'h0000;
         seen     <= 1'b0;
         locked_o <= 1'b0;
      end
      else if (zc_i)
      begin
         // Lock after one half cycle, then follow every crossing
         if (seen)
         begin
            half_period_o <= cnt;
            locked_o      <= 1'b1;
         end
         seen <= 1'b1;
         cnt  <= 16'h0001;
      end
      else if (cnt != `LMC_PER_MAX)
      begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule // lmc_tracker

// [testbench/lmc_actuator.sv]
// Behavioural resonant actuator: back-EMF presence and zero crossings
module lmc_actuator
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        drive_en_i,
   input  wire logic        brake_i,
   input  wire logic        alive_i,
   input  wire logic [15:0] half_i,
   output logic             zc_o,
   output logic             bemf_valid_o
);
   logic [7:0]  energy;
   logic [15:0] ph;
   // Motion builds with drive and drains when coasting or braked
   assign bemf_valid_o = alive_i && energy != 8'h00;
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         energy <= 8'h00;
         ph     <= 16'h0000;
         zc_o   <= 1'b0;
      end
      else
      begin
         if (drive_en_i && !brake_i && energy != 8'hFF)
            energy <= energy + 8'h01;
         else if (!(drive_en_i && !brake_i) && energy != 8'h00)
            energy <= energy - 8'h01;
         ph   <= (ph >= half_i - 16'h0001) ? 16'h0000 : ph + 16'h0001;
         zc_o <= bemf_valid_o && ph == 16'h0000;
      end
endmodule // lmc_actuator

// [testbench/lmc_checker.sv]
// Port assertions for the loop mode control
module lmc_checker
(
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic       wave_active_i,
   input wire logic       bemf_valid_i,
   input wire logic       overdrive_o,
   input wire logic       brake_o,
   input wire logic       gain_boost_o,
   input wire logic       lra_mode_o,
   input wire logic       open_loop_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic       boost_en;
   logic [7:0] boost_cnt;
   // Shadow of the boost bit, so boost can be tied to software intent
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         boost_en  <= 1'b0;
         boost_cnt <= 8'h00;
      end
      else
      begin
         if (wr_i && addr_i == 8'h1F)
            boost_en <= wdata_i[7];
         boost_cnt <= gain_boost_o ? boost_cnt + 8'h01 : 8'h00;
      end
   a_read_slot_only: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its slot");
   a_type_select: assert property ((wr_i && addr_i == 8'h1A) ##1 !(wr_i && addr_i == 8'h1A)
      |-> ##1 lra_mode_o == $past(wdata_i[7], 2)) else $error("actuator type not applied");
   a_od_brake_apart: assert property (!(overdrive_o && brake_o)) else $error("overdrive and brake together");
   a_idle_no_od: assert property (!wave_active_i [*2] |-> !overdrive_o) else $error("overdrive while idle");
   a_brake_needs_bemf: assert property (!bemf_valid_i [*2] |-> !brake_o) else $error("brake without bemf");
   a_boost_enabled: assert property (gain_boost_o |-> boost_en || $past(boost_en))
      else $error("boost while disabled");
   a_boost_window: assert property (boost_cnt <= 8'h40) else $error("boost window too long");
   a_open_lra_only: assert property (open_loop_o |-> lra_mode_o || $past(lra_mode_o))
      else $error("open loop outside resonant mode");
   c_brake: cover property (brake_o);
   c_open: cover property (open_loop_o && !bemf_valid_i);
   c_boost: cover property (gain_boost_o);
endmodule // lmc_checker

bind lmc_loop_ctrl lmc_checker u_chk (.*);

// [testbench/testbench.sv]
// Self-checking bench for the loop mode control
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic       wave_active_i = 1'b0, alive = 1'b1;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, d = 8'h00;
   logic [1:0] seen = 2'h0;
   int         bad_count = 0, comparisons = 0;
   wire  [7:0] rdata_o;
   wire        zc_i, bemf_valid_i, drive_phase_o, drive_en_o, overdrive_o;
   wire        brake_o, gain_boost_o, lra_mode_o, open_loop_o, synced_o;
   wire  [4:0] flags = {drive_phase_o, lra_mode_o, open_loop_o, synced_o, brake_o};
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) seen <= seen | {gain_boost_o, overdrive_o};
   lmc_loop_ctrl dut (.*);
   lmc_actuator act (.clk_i(clk_i), .resetn_i(resetn_i), .drive_en_i(drive_en_o), .brake_i(brake_o),
      .alive_i(alive), .half_i(16'h1080), .zc_o(zc_i), .bemf_valid_o(bemf_valid_i));
   task automatic close_out();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      rd(a);
      check($sformatf("reg %h", a), {8'h00, e}, {8'h00, d & m});
   endtask
   task automatic wait_for(input int idx, input logic lvl, input int lim);
      int n;
      for (n = 0; n < lim && flags[idx] !== lvl; n++)
         @(posedge clk_i) #1;
      check($sformatf("flag %0d", idx), {15'h0, lvl}, {15'h0, flags[idx]});
      if (n >= lim)
         close_out();
   endtask
   // Overdrive and brake must stay off for the whole stretch
   task automatic quiet(input int c);
      repeat (c)
      begin
         @(posedge clk_i) #1;
         if ((overdrive_o | brake_o) !== 1'b0)
            check("quiet drive", 16'h0, 16'h1);
      end
   endtask
   // Cycles between two polarity flips of the drive
   task automatic flip_time(output int n);
      logic p;
      wait_for(4, !drive_phase_o, 9000);
      p = drive_phase_o;
      for (n = 0; n < 9000 && drive_phase_o === p; n++)
         @(posedge clk_i) #1;
      if (drive_phase_o === p)
      begin
         check("flip wait", 16'h0, 16'h1);
         close_out();
      end
   endtask
   task automatic t_regs();
      rd_chk(8'h1A, 8'hFF, 8'h00);
      rd_chk(8'h1F, 8'hFF, 8'h00);
      rd_chk(8'h20, 8'hFF, 8'h33);
      rd_chk(8'h30, 8'hFF, 8'h13);
      wr(8'h55, 8'hA5);
      rd_chk(8'h55, 8'hFF, 8'h00);
      wr(8'h20, 8'h01);
      wr(8'h30, 8'h22);
      rd_chk(8'h20, 8'hFF, 8'h01);
   endtask
   task automatic t_track();
      wr(8'h1A, 8'h80);
      wait_for(3, 1'b1, 4);
      wr(8'h1F, 8'h80);
      @(posedge clk_i) wave_active_i <= 1'b1;
      wait_for(1, 1'b1, 20000);
      check("overdrive", 16'h1, {15'h0, seen[0]});
      check("boost", 16'h1, {15'h0, seen[1]});
      check("drive enable", 16'h1, {15'h0, drive_en_o});
      rd_chk(8'h22, 8'hFF, 8'h10);
      @(posedge clk_i) wave_active_i <= 1'b0;
      wait_for(0, 1'b1, 100);
      wait_for(0, 1'b0, 2000);
      check("drive off", 16'h0, {15'h0, drive_en_o});
   endtask
   task automatic t_fallback();
      int n;
      @(posedge clk_i) wave_active_i <= 1'b1;
      wait_for(1, 1'b1, 20000);
      @(posedge clk_i) alive <= 1'b0;
      wait_for(2, 1'b1, 20000);
      flip_time(n);
      check("fallback half period", 16'h0FA0, 16'(n));
      @(posedge clk_i) alive <= 1'b1;
      wait_for(1, 1'b1, 20000);
      wait_for(2, 1'b0, 8);
      @(posedge clk_i) wave_active_i <= 1'b0;
      wait_for(0, 1'b1, 100);
      wait_for(0, 1'b0, 2000);
   endtask
   task automatic t_auto();
      int n;
      wr(8'h1F, 8'h20);
      @(posedge clk_i) wave_active_i <= 1'b1;
      @(posedge clk_i) alive <= 1'b0;
      d = 8'h00;
      for (n = 0; n < 9000 && d[3] !== 1'b1; n++)
         rd(8'h31);
      check("auto latch", 16'h1, {15'h0, d[3]});
      if (d[3] !== 1'b1)
         close_out();
      flip_time(n);
      check("open half period", 16'h07B2, 16'(n));
      @(posedge clk_i) alive <= 1'b1;
      quiet(16000);
      check("one way", 16'h1, {15'h0, open_loop_o});
      @(posedge clk_i) wave_active_i <= 1'b0;
      quiet(400);
      @(posedge clk_i) wave_active_i <= 1'b1;
      rd_chk(8'h31, 8'h08, 8'h00);
   endtask
   initial
   begin
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_regs();
      t_track();
      t_fallback();
      t_auto();
      close_out();
   end
endmodule // testbench
